// >>> core/ais_pkg.sv
package ais_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_SEL = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [15:0] SEL_RST = 16'h0000;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int SEL_W = 16;
   localparam int CTRL_RUN_BIT = 0;
   localparam int STAT_POS_LSB = 0;
   localparam int STAT_VALID_BIT = 8;
   localparam int STAT_WRAP_BIT = 9;

   // ****************************************
   // Source codes toward the analog mux
   // ****************************************
   localparam int NUM_EXT = 13;
   localparam logic [3:0] POS_CTU = 4'hD;
   localparam logic [3:0] POS_INTREF = 4'hE;
   localparam logic [3:0] POS_GND = 4'hF;
   localparam logic [4:0] SRC_CTU = 5'h0D;
   localparam logic [4:0] SRC_INTREF = 5'h0E;
   localparam logic [4:0] SRC_GND = 5'h0F;
   localparam logic [4:0] SRC_LOWREF = 5'h10;
   localparam logic [4:0] SRC_NONE = 5'h00;

   typedef enum logic {
      SEQ_IDLE,
      SEQ_RUN
   } ais_seq_st_t;

   // Next selected position after from_pos, ascending, wrapping
   function automatic logic [3:0] ais_next_sel(input logic [15:0] mask,
                                               input logic [3:0] from_pos);
      logic [3:0] idx;
      logic found;
      logic [3:0] res;
      found = 1'b0;
      res = from_pos;
      for (int i = 1; i <= 16; i++) begin
         idx = from_pos + 4'(i);
         if (!found && mask[idx]) begin
            found = 1'b1;
            res = idx;
         end
      end
      return res;
   endfunction

endpackage

// >>> core/ais_scan_seq.sv
`timescale 1ns/10ps
module ais_scan_seq
   import ais_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Sequencer link
   ais_seq_if.seq sif
);

   ais_seq_st_t st_ff;
   ais_seq_st_t nxt_st;
   logic [3:0] pos_ff;
   logic [3:0] nxt_pos;
   logic wrap_ff;
   logic nxt_wrap;

   wire any_sel = |sif.mask;
   // From 15 the search lands on the lowest selected position
   wire [3:0] from_pos = (st_ff == SEQ_RUN) ? pos_ff : 4'hF;
   wire [3:0] pick = ais_next_sel(sif.mask, from_pos);
   wire wrapped = (st_ff == SEQ_RUN) && (pick <= from_pos);

   always_comb begin
      nxt_st = st_ff;
      nxt_pos = pos_ff;
      nxt_wrap = 1'b0;
      case (st_ff)
         SEQ_IDLE: begin
            if (sif.run && any_sel) begin
               nxt_st = SEQ_RUN;
               nxt_pos = pick;
            end
         end
         SEQ_RUN: begin
            if (!sif.run || !any_sel) begin
               nxt_st = SEQ_IDLE;
            end else if (sif.adv) begin
               nxt_pos = pick;
               nxt_wrap = wrapped;
            end
         end
         default: nxt_st = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_ff <= SEQ_IDLE;
         pos_ff <= 4'h0;
         wrap_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         pos_ff <= nxt_pos;
         wrap_ff <= nxt_wrap;
      end
   end

   assign sif.pos = pos_ff;
   assign sif.valid = (st_ff == SEQ_RUN);
   assign sif.wrap = wrap_ff;

endmodule

// >>> core/ais_scan_top.sv
`timescale 1ns/10ps
// Summary of operation
// - Set select bit includes its source
// - Clear select bit skips its source
// - Bits 0 to 12 are external channels
// - Bit 13 scans the charge time unit
// - Bit 14 scans internal voltage reference
// - Bit 15 scans the ground node
// - Missing channels convert low reference voltage
// - Upper sixteen bits read zero, ignore writes
module ais_scan_top
   import ais_pkg::*;
#(
   parameter int NUM_AN = NUM_EXT
)
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Register port
   input wire logic [7:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   // Converter side
   input wire logic i_conv_done,
   output logic [4:0] o_src_code,
   output logic o_src_valid,
   output logic o_scan_wrap
);

   // ****************************************
   // Source mapping
   // ****************************************
   localparam logic [4:0] AN_LIM = 5'(NUM_AN);

   function automatic logic [4:0] ais_src_map(input logic [3:0] pos);
      logic [4:0] code;
      code = SRC_LOWREF;
      case (pos)
         POS_CTU: code = SRC_CTU;
         POS_INTREF: code = SRC_INTREF;
         POS_GND: code = SRC_GND;
         default: begin
            if ({1'b0, pos} < AN_LIM) begin
               code = {1'b0, pos};
            end else begin
               code = SRC_LOWREF;
            end
         end
      endcase
      return code;
   endfunction

   // ****************************************
   // Register decode
   // ****************************************
   logic [15:0] sel_ff;
   logic [15:0] nxt_sel;
   logic run_ff;
   logic nxt_run;
   logic wrap_st_ff;
   logic nxt_wrap_st;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic [4:0] code_ff;
   logic valid_ff;

   ais_seq_if sif();

   // Exact decode: unmapped offsets read zero, drop writes
   wire hit_sel = (i_reg_addr == OFS_SEL);
   wire hit_ctrl = (i_reg_addr == OFS_CTRL);
   wire hit_stat = (i_reg_addr == OFS_STAT);
   wire wr_sel = i_reg_wr && hit_sel;
   wire wr_ctrl = i_reg_wr && hit_ctrl;
   wire wr_stat = i_reg_wr && hit_stat;
   wire clr_wrap = wr_stat && i_reg_wdata[STAT_WRAP_BIT];

   // only the low half is stored
   assign nxt_sel = wr_sel ? i_reg_wdata[SEL_W-1:0] : sel_ff;
   assign nxt_run = wr_ctrl ? i_reg_wdata[CTRL_RUN_BIT] : run_ff;
   // Set wins so a wrap in the clearing cycle is kept
   assign nxt_wrap_st = sif.wrap | (wrap_st_ff & ~clr_wrap);

   wire [31:0] rd_sel = {16'h0000, sel_ff};
   wire [31:0] rd_ctrl = {31'h0000_0000, run_ff};
   wire [31:0] rd_stat = (32'(wrap_st_ff) << STAT_WRAP_BIT)
                         | (32'(sif.valid) << STAT_VALID_BIT)
                         | (32'(sif.pos) << STAT_POS_LSB);
   wire [31:0] rd_mux = hit_sel ? rd_sel :
                        hit_ctrl ? rd_ctrl :
                        hit_stat ? rd_stat : RD_ZERO;
   // Data stand only in the cycle after the read strobe
   assign nxt_rdata = i_reg_rd ? rd_mux : RD_ZERO;

   // ****************************************
   // Register state
   // ****************************************
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         sel_ff <= SEL_RST;
         run_ff <= 1'b0;
         wrap_st_ff <= 1'b0;
         rdata_ff <= RD_ZERO;
      end else begin
         sel_ff <= nxt_sel;
         run_ff <= nxt_run;
         wrap_st_ff <= nxt_wrap_st;
         rdata_ff <= nxt_rdata;
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   // Run off or empty select stops the scan next edge
   assign sif.mask = sel_ff;
   assign sif.run = run_ff;
   // Converter done is on this clock, no sync needed
   assign sif.adv = i_conv_done && run_ff;

   ais_scan_seq u_seq (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .sif(sif)
   );

   // ****************************************
   // Mux code output
   // ****************************************
   // channel map, missing channels to low ref
   wire [4:0] nxt_code = sif.valid ? ais_src_map(sif.pos) : SRC_NONE;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         code_ff <= SRC_NONE;
         valid_ff <= 1'b0;
      end else begin
         code_ff <= nxt_code;
         valid_ff <= sif.valid;
      end
   end

   assign o_reg_rdata = rdata_ff;
   assign o_src_code = code_ff;
   assign o_src_valid = valid_ff;
   assign o_scan_wrap = sif.wrap;

   // ****************************************
   // Checks
   // ****************************************
   // Select as it stood before the last edge
   logic [15:0] sel_d_ff;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         sel_d_ff <= SEL_RST;
      end else begin
         sel_d_ff <= sel_ff;
      end
   end

   upper_zero_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      1'b1 |-> o_reg_rdata[31:16] == 16'h0000)
      else $error("upper half of read data not zero");

   sel_readback_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_reg_wr && i_reg_addr == OFS_SEL) ##1 (i_reg_rd && i_reg_addr == OFS_SEL)
      |=> o_reg_rdata[15:0] == $past(i_reg_wdata[15:0], 2))
      else $error("select readback differs from written value");

   adv_pick_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (sif.adv && sif.valid && sel_ff != 16'h0000 && nxt_run)
      |=> sel_d_ff[sif.pos])
      else $error("advance landed on an unselected source");

   order_asc_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (sif.adv && sif.valid && nxt_run && ((sel_ff >> sif.pos) > 16'h0001))
      |=> sif.pos > $past(sif.pos) && !sif.wrap)
      else $error("scan did not ascend");

   wrap_low_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (sif.adv && sif.valid && nxt_run && sel_ff != 16'h0000
       && ((sel_ff >> sif.pos) <= 16'h0001))
      |=> sif.wrap && (sel_d_ff & ((16'h0001 << sif.pos) - 16'h0001)) == 16'h0000
          ##1 wrap_st_ff)
      else $error("wrap did not go to lowest selected source");

   map_chan_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (sif.valid && {1'b0, sif.pos} < AN_LIM) |=> o_src_code == {1'b0, $past(sif.pos)}
      && o_src_valid)
      else $error("external channel code wrong");

   map_ctu_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (sif.valid && sif.pos == POS_CTU) |=> o_src_code == SRC_CTU)
      else $error("charge time unit code wrong");

   map_intref_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (sif.valid && sif.pos == POS_INTREF) |=> o_src_code == SRC_INTREF)
      else $error("internal reference code wrong");

   map_gnd_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (sif.valid && sif.pos == POS_GND) |=> o_src_code == SRC_GND)
      else $error("ground code wrong");

   map_lowref_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (sif.valid && {1'b0, sif.pos} >= AN_LIM && sif.pos < POS_CTU)
      |=> o_src_code == SRC_LOWREF)
      else $error("missing channel not sent to low reference");

   reset_clear_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      $fell(i_rst) |-> sel_ff == 16'h0000 && !o_src_valid)
      else $error("select bits not clear after reset");

   empty_idle_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (sel_ff == 16'h0000) [*2] |=> !o_src_valid)
      else $error("scan active with nothing selected");

   rdata_idle_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      !i_reg_rd |=> o_reg_rdata == RD_ZERO)
      else $error("read data not zero outside a read");

   rd_unmapped_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_reg_rd && !hit_sel && !hit_ctrl && !hit_stat) |=> o_reg_rdata == RD_ZERO)
      else $error("unmapped read not zero");

   sel_read_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_reg_rd && hit_sel) |=> o_reg_rdata == {16'h0000, $past(sel_ff)})
      else $error("select read data wrong");

   sel_write_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_reg_wr && hit_sel) |=> sel_ff == $past(i_reg_wdata[15:0]))
      else $error("select write not stored");

   sel_hold_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      !(i_reg_wr && hit_sel) |=> $stable(sel_ff))
      else $error("select changed without a select write");

   start_low_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (!sif.valid && run_ff && sel_ff != 16'h0000)
      |=> sif.valid && sel_d_ff[sif.pos]
          && (sel_d_ff & ((16'h0001 << sif.pos) - 16'h0001)) == 16'h0000)
      else $error("scan did not start at lowest selected source");

   stop_idle_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      !run_ff |=> !sif.valid && !sif.wrap)
      else $error("scan still running after stop");

   pos_hold_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (sif.valid && !sif.adv) |=> $stable(sif.pos) && !sif.wrap)
      else $error("position moved without an advance");

   code_none_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      !sif.valid |=> o_src_code == SRC_NONE && !o_src_valid)
      else $error("source code shown while scan idle");

   // Sticky wrap: set wins over a clear
   wrap_set_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      sif.wrap |=> wrap_st_ff)
      else $error("wrap not recorded in status");

   wrap_keep_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (wrap_st_ff && !clr_wrap) |=> wrap_st_ff)
      else $error("wrap flag lost without a clear");

   wrap_clear_a: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (clr_wrap && !sif.wrap) |=> !wrap_st_ff)
      else $error("wrap flag not cleared");

endmodule

// >>> core/ais_seq_if.sv
`timescale 1ns/10ps
interface ais_seq_if;
   logic [15:0] mask;
   logic run;
   logic adv;
   logic [3:0] pos;
   logic valid;
   logic wrap;
   modport ctl(output mask, output run, output adv, input pos, input valid, input wrap);
   modport seq(input mask, input run, input adv, output pos, output valid, output wrap);
endinterface

// >>> tb/test_adc_input_scan_select.sv
`timescale 1ns/10ps
module test_adc_input_scan_select;
   import ais_pkg::*;
   // ***********************
   // Signals
   // ***********************
   logic i_core_clk;
   logic i_rst;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] o_reg_rdata;
   logic conv_done;
   logic [4:0] o_src_code;
   logic [4:0] src_code_s;
   logic o_src_valid;
   logic o_scan_wrap;
   int bad_count;
   int n_tests;
   int seed;
   logic [15:0] corner [5] = '{16'h8005, 16'h0001, 16'hFFFF, 16'hE000, 16'h0080};

   ais_scan_top #(.NUM_AN(NUM_EXT)) u_ais_scan_top (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(o_reg_rdata), .i_conv_done(conv_done),
      .o_src_code(o_src_code), .o_src_valid(o_src_valid), .o_scan_wrap(o_scan_wrap));
   // Small variant: only five physical inputs
   ais_scan_top #(.NUM_AN(5)) u_ais_scan_top_small (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(), .i_conv_done(conv_done),
      .o_src_code(src_code_s), .o_src_valid(), .o_scan_wrap());

   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   // ***********************
   // Expectations
   // ***********************
   function automatic logic [3:0] nxt(input logic [15:0] m, input logic [3:0] p);
      logic [3:0] q;
      q = p;
      for (int i = 0; i < 16; i++) begin
         q = q + 4'h1;
         if (m[q]) return q;
      end
      return p;
   endfunction

   function automatic logic [4:0] code_of(input logic [3:0] p, input int n);
      if (p > 4'hC || int'(p) < n) return {1'b0, p};
      return 5'h10;
   endfunction

   // ***********************
   // Bus and check tasks
   // ***********************
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge i_core_clk);
      reg_wr <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge i_core_clk);
      reg_rd <= 1'b0;
      #1 d = o_reg_rdata;
   endtask

   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(what, exp, d);
   endtask

   // Write then read with no gap between the strobes
   task automatic wr_rchk(input string what, input logic [7:0] a, input logic [31:0] d,
                          input logic [31:0] exp);
      logic [31:0] got;
      @(posedge i_core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge i_core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge i_core_clk);
      reg_rd <= 1'b0;
      #1 got = o_reg_rdata;
      chk(what, exp, got);
   endtask

   task automatic wait_valid();
      for (int k = 0; k < 10 && o_src_valid !== 1'b1; k++) begin
         @(posedge i_core_clk);
         #1;
      end
      if (o_src_valid !== 1'b1) begin
         bad_count++;
         $display("[ERR] scan start expected 1 seen %b", o_src_valid);
         conclude();
      end
   endtask

   task automatic run_scan(input logic [15:0] m);
      logic [3:0] p;
      logic [3:0] q;
      logic [31:0] s;
      wr(OFS_SEL, {16'h0000, m});
      wr(OFS_CTRL, 32'h0000_0001);
      wait_valid();
      p = nxt(m, 4'hF);
      for (int k = 0; k < 20; k++) begin
         chk("src code", code_of(p, NUM_EXT), o_src_code);
         chk("src code small", code_of(p, 5), src_code_s);
         q = nxt(m, p);
         @(posedge i_core_clk);
         conv_done <= 1'b1;
         @(posedge i_core_clk);
         conv_done <= 1'b0;
         #1 chk("wrap pulse", q <= p, o_scan_wrap);
         @(posedge i_core_clk);
         #1 p = q;
      end
      rd(OFS_STAT, s);
      chk("status flags", 2'b11, s[9:8]);
      chk("status pos", p, s[3:0]);
      wr(OFS_STAT, 32'h0000_0200);
      rd(OFS_STAT, s);
      chk("wrap cleared", 1'b0, s[9]);
      wr(OFS_CTRL, 32'h0000_0000);
      repeat (3) @(posedge i_core_clk);
      #1 chk("valid stop", 1'b0, o_src_valid);
      chk("code stop", 5'h00, o_src_code);
   endtask

   // ***********************
   // Main sequence
   // ***********************
   initial begin
      logic [15:0] m;
      seed = 98136;
      bad_count = 0;
      n_tests = 0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      conv_done = 1'b0;
      i_rst = 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_rst <= 1'b0;
      rchk("select reset", OFS_SEL, 32'h0000_0000);
      rchk("control reset", OFS_CTRL, 32'h0000_0000);
      wr_rchk("select upper", OFS_SEL, 32'hFFFF_FFFF, 32'h0000_FFFF);
      @(posedge i_core_clk);
      #1 chk("rdata idle", 32'h0000_0000, o_reg_rdata);
      wr(8'h0C, 32'h1234_5678);
      rchk("unmapped", 8'h0C, 32'h0000_0000);
      rchk("select kept", OFS_SEL, 32'h0000_FFFF);
      // Nothing selected: the scan must not start
      wr(OFS_SEL, 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0001);
      repeat (4) @(posedge i_core_clk);
      #1 chk("valid empty", 1'b0, o_src_valid);
      wr(OFS_CTRL, 32'h0000_0000);
      for (int t = 0; t < 12; t++) begin
         m = (t < 5) ? corner[t] : 16'($random(seed));
         if (m == 16'h0000) m = 16'h0001;
         run_scan(m);
      end
      // Reset in mid-scan clears the selection
      wr(OFS_SEL, 32'h0000_00F0);
      wr(OFS_CTRL, 32'h0000_0001);
      wait_valid();
      // Advances on two cycles in a row: 4 to 5 to 6
      @(posedge i_core_clk);
      conv_done <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      conv_done <= 1'b0;
      @(posedge i_core_clk);
      #1 chk("back to back", code_of(4'h6, NUM_EXT), o_src_code);
      chk("back to back small", code_of(4'h6, 5), src_code_s);
      @(posedge i_core_clk);
      i_rst <= 1'b1;
      @(posedge i_core_clk);
      i_rst <= 1'b0;
      #1 chk("valid reset", 1'b0, o_src_valid);
      rchk("select after reset", OFS_SEL, 32'h0000_0000);
      conclude();
   end
endmodule
